//--- design/pic_consts.svh
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH

// Register indices
`define PIC_IDX_FRAME_CTRL   8'h37
`define PIC_IDX_HCOMP_CTRL   8'h40
`define PIC_IDX_HSTR_EN      8'h41
`define PIC_IDX_VCOMP_CTRL   8'h48
`define PIC_IDX_VS0_HIGH     8'h49
`define PIC_IDX_VS0_LOW      8'h4a
`define PIC_IDX_VS1_HIGH     8'h4b
`define PIC_IDX_VS1_LOW      8'h4c
`define PIC_IDX_REP_SPACING  8'h4d
`define PIC_IDX_VSEL_DISABLE 8'h4e

// Reset value of every register
`define PIC_REG_RESET        8'h00

// Frame pulse control fields
`define PIC_FS_DELAY_DIS     7
`define PIC_FS_SELECT        6
`define PIC_FS_WIDTH_HI      5
`define PIC_FS_WIDTH_LO      3
`define PIC_FS_RW_MASK       8'hf8

// Horizontal control fields
`define PIC_H_GFX_EN         5
`define PIC_H_PRIO_HI        4
`define PIC_H_PRIO_LO        3
`define PIC_H_TEXT_EN        2
`define PIC_H_CENTER_EN      1
`define PIC_H_MASTER_EN      0
`define PIC_HSTR_RW_MASK     8'h0f
`define PIC_HSTR_1024        2
`define PIC_HSTR_800         1
`define PIC_HSTR_640         0

// Text priority codes
`define PIC_PRIO_KEEP        2'h0
`define PIC_PRIO_NONE        2'h1
`define PIC_PRIO_NINE        2'h2
`define PIC_PRIO_TEN         2'h3

// Vertical control fields
`define PIC_V_TEXT_EN        4
`define PIC_V_ORDER          3
`define PIC_V_REP_EN         2
`define PIC_V_CENTER_EN      1
`define PIC_V_MASTER_EN      0

// Selective vertical stretching bits
`define PIC_VS_G600          5
`define PIC_VS_G480          4
`define PIC_VS_G400          3
`define PIC_VS_G350          2
`define PIC_VS_T400          1
`define PIC_VS_T350          0

// Glyph widths, mode widths and heights
`define PIC_GLYPH8           4'h8
`define PIC_GLYPH9           4'h9
`define PIC_GLYPH10          4'ha
`define PIC_COLS_1024        12'h400
`define PIC_COLS_800         12'h320
`define PIC_COLS_640         12'h280
`define PIC_ROWS_600         12'h258
`define PIC_ROWS_480         12'h1e0
`define PIC_ROWS_400         12'h190
`define PIC_ROWS_350         12'h15e
`define PIC_FONT_LINES       5'h10

`endif

//--- design/pic_pkg.sv
package pic_pkg;

    typedef enum logic [2:0] {
        PIC_FS_IDLE  = 3'b001,
        PIC_FS_DELAY = 3'b010,
        PIC_FS_PULSE = 3'b100
    } pic_fs_state_e;

    typedef logic [10:0] pic_delay_t;

endpackage : pic_pkg

//--- design/pic_frame_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pic_frame_if;
    logic                frame_select;
    logic                delay_disable;
    logic [2:0]          width_m1;
    pic_pkg::pic_delay_t delay_m1;
    logic                crt_vsync;
    logic                line_strobe;
    logic                frame_start;

    modport ctrl (output frame_select, delay_disable, width_m1, delay_m1,
                  output crt_vsync, line_strobe, input frame_start);
    modport gen  (input frame_select, delay_disable, width_m1, delay_m1,
                  input crt_vsync, line_strobe, output frame_start);
endinterface : pic_frame_if

`default_nettype wire

//--- design/pic_frame_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "pic_consts.svh"

module pic_frame_gen
(
    input  wire logic    clk_i,
    input  wire logic    resetn_i,
    pic_frame_if.gen     fs
);

    pic_pkg::pic_fs_state_e state;
    pic_pkg::pic_delay_t    count;
    logic                   vsync_q;
    logic                   vsync_rise;

    assign vsync_rise = fs.crt_vsync & ~vsync_q;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            vsync_q <= 1'b0;
        else
            vsync_q <= fs.crt_vsync;
    end

    // -------------------------------------------------------------
    // Own pulse: optional delay then width, counted in panel lines
    // -------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= pic_pkg::PIC_FS_IDLE;
            count <= '0;
        end
        else if (fs.frame_select)
        begin
            state <= pic_pkg::PIC_FS_IDLE;
            count <= '0;
        end
        else
        begin
            case (state)
                pic_pkg::PIC_FS_IDLE:
                begin
                    if (vsync_rise && fs.delay_disable)
                    begin
                        state <= pic_pkg::PIC_FS_PULSE;
                        count <= {8'h00, fs.width_m1};
                    end
                    else if (vsync_rise)
                    begin
                        state <= pic_pkg::PIC_FS_DELAY;
                        count <= fs.delay_m1;
                    end
                end
                pic_pkg::PIC_FS_DELAY:
                begin
                    if (fs.line_strobe && count == '0)
                    begin
                        state <= pic_pkg::PIC_FS_PULSE;
                        count <= {8'h00, fs.width_m1};
                    end
                    else if (fs.line_strobe)
                        count <= count - 11'h001;
                end
                pic_pkg::PIC_FS_PULSE:
                begin
                    if (fs.line_strobe && count == '0)
                        state <= pic_pkg::PIC_FS_IDLE;
                    else if (fs.line_strobe)
                        count <= count - 11'h001;
                end
                default:
                begin
                    state <= pic_pkg::PIC_FS_IDLE;
                    count <= '0;
                end
            endcase
        end
    end

    // Select bit copies CRT sync and ignores the delay disable
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            fs.frame_start <= 1'b0;
        else if (fs.frame_select)
            fs.frame_start <= fs.crt_vsync;
        else
            fs.frame_start <= (state == pic_pkg::PIC_FS_PULSE);
    end

endmodule : pic_frame_gen

`default_nettype wire

//--- design/pic_panel_comp.sv
`timescale 1ns/1ps
`default_nettype none
`include "pic_consts.svh"

module pic_panel_comp
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  reg_index_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        crt_vsync_i,
    input  wire logic        line_strobe_i,
    input  wire logic [10:0] frame_delay_m1_i,
    input  wire logic        text_mode_i,
    input  wire logic        glyph_nine_i,
    input  wire logic [7:0]  text_cols_i,
    input  wire logic [11:0] gfx_cols_i,
    input  wire logic        pixel_double_i,
    input  wire logic [11:0] panel_cols_i,
    input  wire logic [11:0] vdisp_end_i,
    input  wire logic        image_fits_i,
    input  wire logic        table_sel_i,
    input  wire logic [4:0]  font_line_i,
    output logic             panel_frame_start_o,
    output logic      [3:0]  glyph_width_o,
    output logic             hstretch_o,
    output logic             hcenter_o,
    output logic      [10:0] border_left_o,
    output logic      [10:0] border_right_o,
    output logic      [1:0]  font_rep_o,
    output logic             line_rep_o,
    output logic      [3:0]  rep_spacing_o,
    output logic             rep_first_o,
    output logic             vcenter_o
);

    // -------------------------------------------------------------
    // Register file
    // -------------------------------------------------------------
    logic [7:0]  frame_ctrl;
    logic [7:0]  hcomp_ctrl;
    logic [7:0]  hstr_en;
    logic [7:0]  vcomp_ctrl;
    logic [15:0] vs_table [2];
    logic [7:0]  rep_spacing;
    logic [7:0]  vsel_disable;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            frame_ctrl   <= `PIC_REG_RESET;
            hcomp_ctrl   <= `PIC_REG_RESET;
            hstr_en      <= `PIC_REG_RESET;
            vcomp_ctrl   <= `PIC_REG_RESET;
            vs_table[0]  <= {`PIC_REG_RESET, `PIC_REG_RESET};
            vs_table[1]  <= {`PIC_REG_RESET, `PIC_REG_RESET};
            rep_spacing  <= `PIC_REG_RESET;
            vsel_disable <= `PIC_REG_RESET;
        end
        else if (reg_wr_i)
        begin
            case (reg_index_i)
                `PIC_IDX_FRAME_CTRL:
                    frame_ctrl <= reg_wdata_i & `PIC_FS_RW_MASK;
                `PIC_IDX_HCOMP_CTRL:  hcomp_ctrl <= reg_wdata_i;
                `PIC_IDX_HSTR_EN:
                    hstr_en <= reg_wdata_i & `PIC_HSTR_RW_MASK;
                `PIC_IDX_VCOMP_CTRL:  vcomp_ctrl <= reg_wdata_i;
                `PIC_IDX_VS0_HIGH:    vs_table[0][15:8] <= reg_wdata_i;
                `PIC_IDX_VS0_LOW:     vs_table[0][7:0]  <= reg_wdata_i;
                `PIC_IDX_VS1_HIGH:    vs_table[1][15:8] <= reg_wdata_i;
                `PIC_IDX_VS1_LOW:     vs_table[1][7:0]  <= reg_wdata_i;
                `PIC_IDX_REP_SPACING: rep_spacing <= reg_wdata_i;
                `PIC_IDX_VSEL_DISABLE: vsel_disable <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Read data is registered; unmapped indices read zero
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            reg_rdata_o <= `PIC_REG_RESET;
        else if (reg_rd_i)
        begin
            case (reg_index_i)
                `PIC_IDX_FRAME_CTRL:   reg_rdata_o <= frame_ctrl;
                `PIC_IDX_HCOMP_CTRL:   reg_rdata_o <= hcomp_ctrl;
                `PIC_IDX_HSTR_EN:      reg_rdata_o <= hstr_en;
                `PIC_IDX_VCOMP_CTRL:   reg_rdata_o <= vcomp_ctrl;
                `PIC_IDX_VS0_HIGH:     reg_rdata_o <= vs_table[0][15:8];
                `PIC_IDX_VS0_LOW:      reg_rdata_o <= vs_table[0][7:0];
                `PIC_IDX_VS1_HIGH:     reg_rdata_o <= vs_table[1][15:8];
                `PIC_IDX_VS1_LOW:      reg_rdata_o <= vs_table[1][7:0];
                `PIC_IDX_REP_SPACING:  reg_rdata_o <= rep_spacing;
                `PIC_IDX_VSEL_DISABLE: reg_rdata_o <= vsel_disable;
                default:               reg_rdata_o <= `PIC_REG_RESET;
            endcase
        end
    end

    // -------------------------------------------------------------
    // Panel frame start
    // -------------------------------------------------------------
    pic_frame_if fs_if ();

    assign fs_if.frame_select  = frame_ctrl[`PIC_FS_SELECT];
    assign fs_if.delay_disable = frame_ctrl[`PIC_FS_DELAY_DIS];
    assign fs_if.width_m1      =
        frame_ctrl[`PIC_FS_WIDTH_HI:`PIC_FS_WIDTH_LO];
    assign fs_if.delay_m1      = frame_delay_m1_i;
    assign fs_if.crt_vsync     = crt_vsync_i;
    assign fs_if.line_strobe   = line_strobe_i;

    pic_frame_gen u_frame_gen
    (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .fs       (fs_if.gen)
    );

    assign panel_frame_start_o = fs_if.frame_start;

    // -------------------------------------------------------------
    // Horizontal compensation
    // -------------------------------------------------------------
    logic        h_master;
    logic        h_text;
    logic        h_gfx;
    logic [1:0]  prio;
    logic [11:0] text_w8;
    logic [11:0] text_w9;
    logic [11:0] text_w10;
    logic [3:0]  next_glyph;
    logic [11:0] image_w;
    logic [11:0] gfx_eff;
    logic        res_en;
    logic        next_hstretch;
    logic [11:0] slack;

    assign h_master = hcomp_ctrl[`PIC_H_MASTER_EN];
    assign h_text   = h_master & hcomp_ctrl[`PIC_H_TEXT_EN];
    assign h_gfx    = h_master & hcomp_ctrl[`PIC_H_GFX_EN];
    assign prio     = hcomp_ctrl[`PIC_H_PRIO_HI:`PIC_H_PRIO_LO];

    assign text_w8  = 12'({4'h0, text_cols_i} * 12'(`PIC_GLYPH8));
    assign text_w9  = 12'({4'h0, text_cols_i} * 12'(`PIC_GLYPH9));
    assign text_w10 = 12'({4'h0, text_cols_i} * 12'(`PIC_GLYPH10));

    always_comb
    begin
        next_glyph = glyph_nine_i ? `PIC_GLYPH9 : `PIC_GLYPH8;
        if (text_mode_i && h_text)
        begin
            case (prio)
                `PIC_PRIO_KEEP:
                    if (glyph_nine_i && text_w9 > panel_cols_i)
                        next_glyph = `PIC_GLYPH8;
                `PIC_PRIO_NONE: ;
                `PIC_PRIO_NINE:
                    if (text_w9 <= panel_cols_i)
                        next_glyph = `PIC_GLYPH9;
                    else
                        next_glyph = `PIC_GLYPH8;
                `PIC_PRIO_TEN:
                    if (text_w10 <= panel_cols_i)
                        next_glyph = `PIC_GLYPH10;
                    else if (text_w9 <= panel_cols_i)
                        next_glyph = `PIC_GLYPH9;
                    else
                        next_glyph = `PIC_GLYPH8;
                default: ;
            endcase
        end
    end

    // Pixel-doubled modes count as the doubled column width
    assign gfx_eff = pixel_double_i ? {gfx_cols_i[10:0], 1'b0}
                                    : gfx_cols_i;

    always_comb
    begin
        case (gfx_eff)
            `PIC_COLS_1024: res_en = hstr_en[`PIC_HSTR_1024];
            `PIC_COLS_800:  res_en = hstr_en[`PIC_HSTR_800];
            `PIC_COLS_640:  res_en = hstr_en[`PIC_HSTR_640];
            default:        res_en = 1'b0;
        endcase
    end

    always_comb
    begin
        case (next_glyph)
            `PIC_GLYPH10: image_w = text_w10;
            `PIC_GLYPH9:  image_w = text_w9;
            default:      image_w = text_w8;
        endcase
        if (!text_mode_i)
            image_w = gfx_eff;
    end

    // Text left narrower than the panel stretches as graphics does
    assign next_hstretch = (panel_cols_i > image_w) &&
                           ((!text_mode_i && h_gfx && res_en) ||
                            (text_mode_i && h_text));

    assign slack = (panel_cols_i > image_w) ? panel_cols_i - image_w
                                            : 12'h000;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            glyph_width_o  <= `PIC_GLYPH8;
            hstretch_o     <= 1'b0;
            hcenter_o      <= 1'b0;
            border_left_o  <= '0;
            border_right_o <= '0;
        end
        else
        begin
            glyph_width_o <= next_glyph;
            hstretch_o    <= next_hstretch;
            hcenter_o     <= h_master & hcomp_ctrl[`PIC_H_CENTER_EN];
            if (h_master && hcomp_ctrl[`PIC_H_CENTER_EN]
                && !next_hstretch)
            begin
                border_left_o  <= slack[11:1];
                border_right_o <= slack[11:1] + {10'h000, slack[0]};
            end
            else
            begin
                border_left_o  <= '0;
                border_right_o <= '0;
            end
        end
    end

    // -------------------------------------------------------------
    // Vertical compensation
    // -------------------------------------------------------------
    logic       v_master;
    logic       height_en;
    logic [3:0] spacing_min;
    logic [3:0] spacing_max;
    logic [1:0] table_entry;
    logic       rep_on;

    assign v_master    = vcomp_ctrl[`PIC_V_MASTER_EN];
    assign spacing_min = rep_spacing[3:0];
    assign spacing_max = rep_spacing[7:4];
    assign rep_on      = v_master & height_en &
                         vcomp_ctrl[`PIC_V_REP_EN];

    // Height control picked from the display end value
    always_comb
    begin
        height_en = 1'b0;
        case (vdisp_end_i)
            `PIC_ROWS_600:
                height_en = !text_mode_i & vsel_disable[`PIC_VS_G600];
            `PIC_ROWS_480:
                height_en = !text_mode_i & vsel_disable[`PIC_VS_G480];
            `PIC_ROWS_400:
                height_en = text_mode_i ? vsel_disable[`PIC_VS_T400]
                                        : vsel_disable[`PIC_VS_G400];
            `PIC_ROWS_350:
                height_en = text_mode_i ? vsel_disable[`PIC_VS_T350]
                                        : vsel_disable[`PIC_VS_G350];
            default:
                height_en = 1'b1;
        endcase
    end

    // Entry n sits at bits 2n+1:2n; late font lines are not copied
    always_comb
    begin
        table_entry = 2'h0;
        for (int i = 0; i < `PIC_FONT_LINES; i++)
        begin
            if (font_line_i == 5'(i))
                table_entry = vs_table[table_sel_i][2*i +: 2];
        end
        if (font_line_i >= `PIC_FONT_LINES)
            table_entry = 2'h0;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            font_rep_o  <= 2'h0;
            line_rep_o  <= 1'b0;
            rep_first_o <= 1'b0;
            vcenter_o   <= 1'b0;
        end
        else
        begin
            font_rep_o  <= (text_mode_i && v_master && height_en &&
                            vcomp_ctrl[`PIC_V_TEXT_EN])
                           ? table_entry : 2'h0;
            line_rep_o  <= rep_on;
            rep_first_o <= text_mode_i &&
                           vcomp_ctrl[`PIC_V_TEXT_EN] &&
                           vcomp_ctrl[`PIC_V_REP_EN] &&
                           vcomp_ctrl[`PIC_V_ORDER];
            vcenter_o   <= v_master & vcomp_ctrl[`PIC_V_CENTER_EN];
        end
    end

    logic panel_frame_start_q;

    // Spacing search: start low, widen once per frame until fit or spacing_max
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rep_spacing_o <= 4'h0;
        else if (!rep_on || (reg_wr_i &&
                 reg_index_i == `PIC_IDX_REP_SPACING))
            rep_spacing_o <= spacing_min;
        else if (fs_if.frame_start && !panel_frame_start_q
                 && !image_fits_i && rep_spacing_o < spacing_max)
            rep_spacing_o <= rep_spacing_o + 4'h1;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            panel_frame_start_q <= 1'b0;
        else
            panel_frame_start_q <= fs_if.frame_start;
    end

endmodule : pic_panel_comp

`default_nettype wire

//--- dv/pic_panel_comp_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pic_panel_comp_sva
(
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic [7:0] reg_index_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       crt_vsync_i,
    input wire logic       text_mode_i,
    input wire logic       glyph_nine_i,
    input wire logic       panel_frame_start_o,
    input wire logic [3:0] glyph_width_o,
    input wire logic       hstretch_o,
    input wire logic       hcenter_o,
    input wire logic       line_rep_o,
    input wire logic       rep_first_o,
    input wire logic       vcenter_o
);
    logic [7:0] hreg;
    logic [7:0] vreg;
    logic       fsel;
    // Shadow copies of the horizontal and vertical control registers and the frame select bit, seen from the write port
    always_ff @(posedge clk_i or negedge resetn_i)
        if (!resetn_i)
            {hreg, vreg, fsel} <= 17'h0;
        else if (reg_wr_i && reg_index_i == 8'h40)
            hreg <= reg_wdata_i;
        else if (reg_wr_i && reg_index_i == 8'h48)
            vreg <= reg_wdata_i;
        else if (reg_wr_i && reg_index_i == 8'h37)
            fsel <= reg_wdata_i[6];

    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    a_glyph_legal: assert property (
        glyph_width_o inside {4'h8, 4'h9, 4'ha}) else $error("bad glyph width");
    a_master_gate: assert property (hstretch_o |-> $past(hreg[0]))
        else $error("stretch without master enable");
    a_center_gate: assert property (hcenter_o |-> $past(&hreg[1:0]))
        else $error("centering without its enables");
    a_vcenter_set: assert property (vcenter_o == $past(&vreg[1:0]))
        else $error("vertical centering wrong");
    a_rep_gate: assert property (line_rep_o |-> $past(vreg[2]))
        else $error("replication without enable");
    a_order_gate: assert property (rep_first_o |-> $past(&vreg[3:2]))
        else $error("replication first without enables");
    a_copy_vsync: assert property (
        $past(fsel) && $past(fsel, 2)
        |-> panel_frame_start_o == $past(crt_vsync_i))
        else $error("frame start does not follow vsync");
    a_text_fixed: assert property (
        $past(resetn_i && text_mode_i && hreg[4:0] == 5'h0d)
        |-> glyph_width_o == ($past(glyph_nine_i) ? 4'h9 : 4'h8))
        else $error("glyph width changed under fixed priority");
endmodule : pic_panel_comp_sva

bind pic_panel_comp pic_panel_comp_sva u_sva (.*);
`default_nettype wire

//--- dv/pic_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module pic_panel_model
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       frame_start_i,
    output logic            line_strobe_o,
    output logic      [3:0] lines_o
);
    logic [1:0] div;
    logic       was_on;
    // Line timing every fourth dot clock; counts lines seen per frame pulse
    assign line_strobe_o = (div == 2'h3);
    always_ff @(posedge clk_i or negedge resetn_i)
        if (!resetn_i)
            {div, was_on, lines_o} <= 7'h0;
        else
        begin
            div    <= div + 2'h1;
            was_on <= frame_start_i;
            if (frame_start_i)
                lines_o <= (was_on ? lines_o : 4'h0) + {3'h0, line_strobe_o};
        end
endmodule : pic_panel_model
`default_nettype wire

//--- dv/pic_panel_comp_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pic_panel_comp_tb_top;
    logic        clk_i, resetn_i, reg_wr_i, reg_rd_i, crt_vsync_i;
    logic        line_strobe_i, text_mode_i, glyph_nine_i, pixel_double_i;
    logic        image_fits_i, table_sel_i, panel_frame_start_o, hstretch_o;
    logic        hcenter_o, line_rep_o, rep_first_o, vcenter_o;
    logic [7:0]  reg_index_i, reg_wdata_i, reg_rdata_o, text_cols_i;
    logic [10:0] frame_delay_m1_i, border_left_o, border_right_o;
    logic [11:0] gfx_cols_i, panel_cols_i, vdisp_end_i;
    logic [4:0]  font_line_i;
    logic [3:0]  glyph_width_o, rep_spacing_o, lines;
    logic [1:0]  font_rep_o;
    logic [24:0] rows [11];
    int          miscompares, checks_done, i;

    pic_panel_comp uut (.*);
    pic_panel_model u_panel (.clk_i, .resetn_i, .lines_o(lines),
        .frame_start_i(panel_frame_start_o), .line_strobe_o(line_strobe_i));

    task automatic chk(input string n, input logic [11:0] e,
                       input logic [11:0] g);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {reg_index_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        {reg_index_i, reg_rd_i} <= {a, 1'b1};
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk("read data", e, reg_rdata_o);
    endtask : rd
    task automatic vrise;
        // Start sync on a line boundary so the pulse spans whole lines
        @(posedge clk_i iff line_strobe_i);
        crt_vsync_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : vrise
    task automatic vfall;
        @(posedge clk_i);
        crt_vsync_i <= 1'b0;
        repeat (60) @(posedge clk_i);
        #1;
    endtask : vfall
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle
    task automatic fl(input logic s, input logic [4:0] n, input logic [1:0] e);
        @(posedge clk_i);
        {table_sel_i, font_line_i} <= {s, n};
        settle();
        chk("font copies", e, font_rep_o);
    endtask : fl
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        give_verdict();
    end
    initial
    begin
        {resetn_i, reg_wr_i, reg_rd_i, crt_vsync_i, glyph_nine_i} = '0;
        {pixel_double_i, table_sel_i, reg_index_i, reg_wdata_i} = '0;
        {text_mode_i, image_fits_i, font_line_i} = 7'h60;
        {text_cols_i, frame_delay_m1_i} = {8'h50, 11'h3};
        {gfx_cols_i, panel_cols_i, vdisp_end_i} = {12'h400, 12'h280, 12'h190};
        rows = '{{8'h05, 1'b1, 12'h2d0, 4'h9}, {8'h05, 1'b1, 12'h280, 4'h8},
                 {8'h05, 1'b0, 12'h280, 4'h8}, {8'h0d, 1'b1, 12'h280, 4'h9},
                 {8'h15, 1'b0, 12'h2d0, 4'h9}, {8'h15, 1'b1, 12'h280, 4'h8},
                 {8'h1d, 1'b0, 12'h320, 4'ha}, {8'h1d, 1'b1, 12'h2d0, 4'h9},
                 {8'h1d, 1'b1, 12'h280, 4'h8}, {8'h1c, 1'b0, 12'h320, 4'h8},
                 {8'h19, 1'b0, 12'h320, 4'h8}};
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(8'h40, 8'h00);
        wr(8'h37, 8'hff);
        rd(8'h37, 8'hf8);
        wr(8'h41, 8'hff);
        rd(8'h41, 8'h0f);
        rd(8'h55, 8'h00);
        $display("test registers done");
        for (i = 0; i < 11; i++)
        begin
            @(posedge clk_i);
            {glyph_nine_i, panel_cols_i} <= rows[i][16:4];
            wr(8'h40, rows[i][24:17]);
            settle();
            chk("glyph width", rows[i][3:0], glyph_width_o);
        end
        wr(8'h40, 8'h0d);
        settle();
        chk("text leftover stretch", 1'b1, hstretch_o);
        @(posedge clk_i);
        {text_mode_i, gfx_cols_i} <= {1'b0, 12'h280};
        wr(8'h40, 8'h21);
        settle();
        chk("graphics stretch", 1'b1, hstretch_o);
        wr(8'h41, 8'h0e);
        settle();
        chk("graphics stretch off", 1'b0, hstretch_o);
        @(posedge clk_i);
        {pixel_double_i, gfx_cols_i} <= {1'b1, 12'h140};
        wr(8'h40, 8'h23);
        settle();
        chk("left border", 12'h050, border_left_o);
        chk("right border", 12'h050, border_right_o);
        $display("test horizontal done");
        wr(8'h37, 8'h90);
        vrise();
        chk("frame start", 1'b1, panel_frame_start_o);
        vfall();
        chk("frame lines", 1'b1, lines >= 4'h3 && lines <= 4'h4);
        wr(8'h37, 8'h10);
        vrise();
        chk("frame start delayed", 1'b0, panel_frame_start_o);
        vfall();
        wr(8'h37, 8'h40);
        vrise();
        chk("frame start copy", 1'b1, panel_frame_start_o);
        vfall();
        chk("frame start copy low", 1'b0, panel_frame_start_o);
        $display("test frame start done");
        @(posedge clk_i);
        text_mode_i <= 1'b1;
        wr(8'h4a, 8'h0b);
        wr(8'h49, 8'hc0);
        wr(8'h4d, 8'h31);
        wr(8'h4e, 8'h3f);
        wr(8'h48, 8'h1f);
        settle();
        chk("vertical centering", 1'b1, vcenter_o);
        chk("replication first", 1'b1, rep_first_o);
        chk("line replication", 1'b1, line_rep_o);
        chk("spacing", 4'h1, rep_spacing_o);
        fl(1'b0, 5'h00, 2'h3);
        fl(1'b0, 5'h01, 2'h2);
        fl(1'b0, 5'h0f, 2'h3);
        fl(1'b0, 5'h10, 2'h0);
        fl(1'b1, 5'h00, 2'h0);
        @(posedge clk_i);
        image_fits_i <= 1'b0;
        vrise();
        vfall();
        chk("spacing step", 4'h2, rep_spacing_o);
        vrise();
        vfall();
        vrise();
        vfall();
        chk("spacing limit", 4'h3, rep_spacing_o);
        wr(8'h4e, 8'h3d);
        settle();
        chk("height disable", 1'b0, line_rep_o);
        $display("test vertical done");
        @(posedge clk_i);
        resetn_i <= 1'b0;
        settle();
        chk("reset spacing", 4'h0, rep_spacing_o);
        chk("reset vcenter", 1'b0, vcenter_o);
        @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(8'h48, 8'h00);
        chk("reset line rep", 1'b0, line_rep_o);
        $display("test reset done");
        give_verdict();
    end
endmodule : pic_panel_comp_tb_top
`default_nettype wire
